// >>> rtl/core_defs.vh
// constants for the instruction execution block
`ifndef CORE_DEFS_VH
`define CORE_DEFS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_INSTR    12'h000
`define OFF_STATUS   12'h004
`define OFF_ACC      12'h008
`define OFF_PC       12'h00c
`define OFF_STACK    12'h010
`define OFF_GUARD    12'h014
`define OFF_FILE_BIT 9
// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define IW_OP_LSB    0
`define IW_DEST_BIT  4
`define IW_F_LSB     8
`define IW_K_LSB     16
// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_C         0
`define ST_DC        1
`define ST_Z         2
`define ST_PD        3
`define ST_TO        4
`define ST_BUSY      5
`define ST_SLEEP     6
`define ST_GIE       7
`define ST_WAKE      8
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_IDLE      4'h0
`define OP_OR_F      4'h1
`define OP_STORE     4'h2
`define OP_LOAD      4'h3
`define OP_RL        4'h4
`define OP_RR        4'h5
`define OP_RETURN_LITERAL_IN_ACCUMULATOR     4'h6
`define OP_RETURN    4'h7
`define OP_INTERRUPT_EXIT_INSTRUCTION    4'h8
`define OP_SLEEP     4'h9
`define OP_LITERAL_MINUS_ACCUMULATOR     4'ha
`define OP_XOR_LITERAL_ACCUMULATOR     4'hb
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_PD       1'b1
`define RST_TO       1'b1
`define RST_PC       13'h0000
`define CLK_NS       100
`define ICYC_NS      400
`define ICYC_CLKS    (`ICYC_NS / `CLK_NS)
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// >>> rtl/exec_alu.v
// combinational operation unit for the accumulator instructions
`timescale 1ns/1ps
`include "core_defs.vh"
module exec_alu (
   // operation
   input  wire [3:0] op,
   input  wire       dest,
   input  wire [7:0] acc,
   input  wire [7:0] fval,
   input  wire [7:0] lit,
   input  wire       c_in,
   // result
   output reg  [7:0] res,
   output reg        c_out,
   output reg        dc_out,
   output reg        upd_c,
   output reg        upd_dc,
   output reg        upd_z,
   output reg        to_acc,
   output reg        to_file
);
   reg [8:0] diff;
   reg [4:0] ndiff;
   always @* begin
      diff    = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
      ndiff   = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      res     = 8'h00;
      c_out   = c_in;
      dc_out  = 1'b0;
      upd_c   = 1'b0;
      upd_dc  = 1'b0;
      upd_z   = 1'b0;
      to_acc  = 1'b0;
      to_file = 1'b0;
      case (op)
         `OP_OR_F: begin
            res = acc | fval;
            upd_z = 1'b1;
            to_acc = ~dest;
            to_file = dest;
         end
         `OP_STORE: begin
            res = acc;
            to_file = 1'b1;
         end
         `OP_LOAD: begin
            res = fval;
            upd_z = 1'b1;
            to_acc = ~dest;
            to_file = dest;
         end
         `OP_RL: begin
            res = {fval[6:0], c_in};
            c_out = fval[7];
            upd_c = 1'b1;
            to_acc = ~dest;
            to_file = dest;
         end
         `OP_RR: begin
            res = {c_in, fval[7:1]};
            c_out = fval[0];
            upd_c = 1'b1;
            to_acc = ~dest;
            to_file = dest;
         end
         `OP_RETURN_LITERAL_IN_ACCUMULATOR: begin
            res = lit;
            to_acc = 1'b1;
         end
         `OP_LITERAL_MINUS_ACCUMULATOR: begin
            // carry set means no borrow
            res = diff[7:0];
            c_out = diff[8];
            dc_out = ndiff[4];
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
            to_acc = 1'b1;
         end
         `OP_XOR_LITERAL_ACCUMULATOR: begin
            res = acc ^ lit;
            upd_z = 1'b1;
            to_acc = 1'b1;
         end
         default: begin
            res = 8'h00;
         end
      endcase
   end
endmodule

// >>> rtl/mcu_logic_return_sleep_ops.v
// instruction execution core with an axi4-lite register port
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "core_defs.vh"
module mcu_logic_return_sleep_ops (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // write address
   input  wire [11:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // read address
   input  wire [11:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // core state
   output reg         oscillator_halted_r
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   function mapped;
      input [11:0] a;
      begin
         mapped = a[`OFF_FILE_BIT] || a == `OFF_INSTR || a == `OFF_STATUS ||
                  a == `OFF_ACC || a == `OFF_PC || a == `OFF_STACK ||
                  a == `OFF_GUARD;
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]  file_mem [0:127];
   reg  [7:0]  acc_r;
   reg  [12:0] pc_r;
   reg         c_r;
   reg         dc_r;
   reg         z_r;
   reg         pd_r;
   reg         to_r;
   reg         gie_r;
   reg  [31:0] instr_r;
   reg         pending_r;
   reg         second_r;
   reg  [7:0]  guard_r;
   reg  [7:0]  presc_r;
   reg  [1:0]  div_r;
   reg  [11:0] awaddr_r;
   reg         aw_full_r;
   reg  [31:0] wdata_r;
   reg  [3:0]  wstrb_r;
   reg         w_full_r;
   integer     i;

   wire        tick;
   wire        busy;
   wire        exec;
   wire        do_write;
   wire [3:0]  op;
   wire        dest;
   wire [6:0]  faddr;
   wire [7:0]  lit;
   wire [7:0]  fval;
   wire [7:0]  res;
   wire        c_out;
   wire        dc_out;
   wire        upd_c;
   wire        upd_dc;
   wire        upd_z;
   wire        to_acc;
   wire        to_file;
   wire        is_ret;
   wire [12:0] head;
   wire [3:0]  depth;
   wire        push;
   wire [31:0] wr_val;
   wire [31:0] status_word;

   // ----------------------------------------
   // instruction cycle divider
   // ----------------------------------------
   assign tick = ({30'h0, div_r} == (`ICYC_CLKS - 1));
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 2'h0;
      end else if (tick) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   // ----------------------------------------
   // decode and execute
   // ----------------------------------------
   assign op     = instr_r[`IW_OP_LSB +: 4];
   assign dest   = instr_r[`IW_DEST_BIT];
   assign faddr  = instr_r[`IW_F_LSB +: 7];
   assign lit    = instr_r[`IW_K_LSB +: 8];
   assign fval   = file_mem[faddr];
   assign busy   = pending_r | second_r;
   // a halted core takes no new instruction until software wakes it
   assign exec   = tick & pending_r & ~oscillator_halted_r;
   assign is_ret = (op == `OP_RETURN_LITERAL_IN_ACCUMULATOR) || (op == `OP_RETURN) || (op == `OP_INTERRUPT_EXIT_INSTRUCTION);

   exec_alu u_alu (
      .op      (op),
      .dest    (dest),
      .acc     (acc_r),
      .fval    (fval),
      .lit     (lit),
      .c_in    (c_r),
      .res     (res),
      .c_out   (c_out),
      .dc_out  (dc_out),
      .upd_c   (upd_c),
      .upd_dc  (upd_dc),
      .upd_z   (upd_z),
      .to_acc  (to_acc),
      .to_file (to_file)
   );

   assign push = do_write && awaddr_r == `OFF_STACK;

   return_stack u_stack (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .push      (push),
      .pop       (exec & is_ret),
      .push_data (wdata_r[12:0]),
      .head      (head),
      .depth_r   (depth)
   );

   // ----------------------------------------
   // axi4-lite write side
   // ----------------------------------------
   // writes stall while an instruction is in flight, so software
   // and the core never update the same state in one cycle
   assign s_axi_awready = ~aw_full_r;
   assign s_axi_wready  = ~w_full_r;
   // a halted core executes nothing, so the wake write must not stall
   assign do_write      = aw_full_r & w_full_r & ~s_axi_bvalid &
                          (~busy | oscillator_halted_r);
   assign wr_val        = s_axi_wdata;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r    <= 1'b0;
         w_full_r     <= 1'b0;
         awaddr_r     <= 12'h000;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= wr_val;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // core registers
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         acc_r               <= 8'h00;
         pc_r                <= `RST_PC;
         c_r                 <= 1'b0;
         dc_r                <= 1'b0;
         z_r                 <= 1'b0;
         pd_r                <= `RST_PD;
         to_r                <= `RST_TO;
         gie_r               <= 1'b0;
         instr_r             <= 32'h0000_0000;
         pending_r           <= 1'b0;
         second_r            <= 1'b0;
         oscillator_halted_r <= 1'b0;
         for (i = 0; i < 128; i = i + 1) begin
            file_mem[i] <= 8'h00;
         end
      end else if (exec) begin
         pending_r <= 1'b0;
         // idle falls through: one cycle, nothing but the pc moves
         pc_r <= is_ret ? head : pc_r + 13'h0001;
         second_r <= is_ret;
         if (to_acc) begin
            acc_r <= res;
         end
         if (to_file) begin
            file_mem[faddr] <= res;
         end
         if (upd_c) begin
            c_r <= c_out;
         end
         if (upd_dc) begin
            dc_r <= dc_out;
         end
         if (upd_z) begin
            z_r <= (res == 8'h00);
         end
         if (op == `OP_INTERRUPT_EXIT_INSTRUCTION) begin
            gie_r <= 1'b1;
         end
         if (op == `OP_SLEEP) begin
            pd_r                <= 1'b0;
            to_r                <= 1'b1;
            oscillator_halted_r <= 1'b1;
         end
      end else if (tick && second_r) begin
         second_r <= 1'b0;
      end else if (do_write) begin
         if (awaddr_r[`OFF_FILE_BIT]) begin
            if (wstrb_r[0]) begin
               file_mem[awaddr_r[8:2]] <= wdata_r[7:0];
            end
         end else begin
            case (awaddr_r)
               `OFF_INSTR: begin
                  instr_r   <= merge(instr_r, wdata_r, wstrb_r);
                  pending_r <= 1'b1;
               end
               `OFF_STATUS: begin
                  if (wstrb_r[0]) begin
                     c_r   <= wdata_r[`ST_C];
                     dc_r  <= wdata_r[`ST_DC];
                     z_r   <= wdata_r[`ST_Z];
                     gie_r <= wdata_r[`ST_GIE];
                  end
                  if (wstrb_r[1] && wdata_r[`ST_WAKE]) begin
                     oscillator_halted_r <= 1'b0;
                  end
               end
               `OFF_ACC: begin
                  if (wstrb_r[0]) begin
                     acc_r <= wdata_r[7:0];
                  end
               end
               `OFF_PC: begin
                  pc_r <= wdata_r[12:0];
               end
               default: begin
                  pc_r <= pc_r;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // guard timer and prescaler
   // ----------------------------------------
   // keeps counting while halted, it has its own oscillator
   always @(posedge aclk) begin
      if (!aresetn) begin
         guard_r <= 8'h00;
         presc_r <= 8'h00;
      end else if (exec && op == `OP_SLEEP) begin
         guard_r <= 8'h00;
         presc_r <= 8'h00;
      end else if (tick) begin
         presc_r <= presc_r + 8'h01;
         if (presc_r == 8'hff) begin
            guard_r <= guard_r + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite read side
   // ----------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;
   assign status_word   = {24'h000000, gie_r, oscillator_halted_r, busy,
                           to_r, pd_r, z_r, dc_r, c_r};

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         if (s_axi_araddr[`OFF_FILE_BIT]) begin
            s_axi_rdata <= {24'h000000, file_mem[s_axi_araddr[8:2]]};
         end else begin
            case ({s_axi_araddr[11:2], 2'h0})
               `OFF_INSTR:  s_axi_rdata <= instr_r;
               `OFF_STATUS: s_axi_rdata <= status_word;
               `OFF_ACC:    s_axi_rdata <= {24'h000000, acc_r};
               `OFF_PC:     s_axi_rdata <= {19'h00000, pc_r};
               `OFF_STACK:  s_axi_rdata <= {28'h0000000, depth};
               `OFF_GUARD:  s_axi_rdata <= {16'h0000, presc_r, guard_r};
               default:     s_axi_rdata <= 32'h0000_0000;
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> rtl/return_stack.v
// eight entry circular return address stack
`timescale 1ns/1ps
module return_stack (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // control
   input  wire        push,
   input  wire        pop,
   input  wire [12:0] push_data,
   // state
   output wire [12:0] head,
   output reg  [3:0]  depth_r
);
   reg [12:0] mem [0:7];
   reg [2:0]  ptr_r;
   integer    i;
   // underflow wraps like a ring; depth only saturates for software view
   assign head = mem[ptr_r - 3'h1];
   always @(posedge aclk) begin
      if (!aresetn) begin
         ptr_r   <= 3'h0;
         depth_r <= 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            mem[i] <= 13'h0000;
         end
      end else if (push) begin
         mem[ptr_r] <= push_data;
         ptr_r      <= ptr_r + 3'h1;
         if (depth_r != 4'h8) begin
            depth_r <= depth_r + 4'h1;
         end
      end else if (pop) begin
         ptr_r <= ptr_r - 3'h1;
         if (depth_r != 4'h0) begin
            depth_r <= depth_r - 4'h1;
         end
      end
   end
endmodule

// >>> tb/core_port_checker_assertions.sv
// concurrent checks on the register port and the halt output
`timescale 1ns/1ps
`include "core_defs.vh"
module core_port_checker (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // write side
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   // read side
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // core state
   input wire        oscillator_halted_r
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // handshake sequences
   // ----------------------------------------
   sequence read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_read_one_cycle: assert property (read_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");
   a_read_data_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before it was taken");
   a_aw_buffer_full: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address ready while address held");
   // bound covers two-cycle returns stalling the write
   a_write_answer: assert property (write_taken |-> ##[1:20] s_axi_bvalid)
      else $error("write answer missing");
   a_write_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer changed before it was taken");
   a_bresp_legal: assert property (s_axi_bvalid |->
      s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR)
      else $error("write response code illegal");
   a_reset_quiet: assert property ($rose(aresetn) |->
      !s_axi_bvalid && !s_axi_rvalid && !oscillator_halted_r)
      else $error("port busy after reset");
   a_halt_holds: assert property ($rose(oscillator_halted_r) |-> oscillator_halted_r [*3])
      else $error("halt dropped without a wake write");
   a_wake_answer: assert property ($fell(oscillator_halted_r) |-> ##[0:2] s_axi_bvalid)
      else $error("wake without a write answer");
endmodule
bind mcu_logic_return_sleep_ops core_port_checker chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .oscillator_halted_r(oscillator_halted_r));

// >>> tb/tb.sv
// self-checking bench for the execution core
`timescale 1ns/1ps
`include "core_defs.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
   num_errors = num_errors + 1; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [11:0] s_axi_awaddr = 12'h000;
   reg         s_axi_awvalid = 1'b0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'h0;
   reg         s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0;
   reg  [11:0] s_axi_araddr = 12'h000;
   reg         s_axi_arvalid = 1'b0;
   reg         s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        oscillator_halted_r;
   integer     num_errors = 0;
   integer     n_compared = 0;
   integer     cycles = 0;
   mcu_logic_return_sleep_ops dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .oscillator_halted_r(oscillator_halted_r));
   always #50 aclk = ~aclk;
   // ----------------------------------------
   // closing and hang guard
   // ----------------------------------------
   task give_verdict;
      begin
         $display("errors %0d compared %0d", num_errors, n_compared);
         if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   // ready is raised late on purpose so the answer must stand
   task axi_wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      reg done;
      begin
         done = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
               r = s_axi_bresp;
               s_axi_bready <= 1'b0;
               done = 1'b1;
            end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
         end
      end
   endtask
   task axi_rd(input [11:0] a, output [31:0] d, output [1:0] r);
      reg done;
      begin
         done = 1'b0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
               d = s_axi_rdata;
               r = s_axi_rresp;
               s_axi_rready <= 1'b0;
               done = 1'b1;
            end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      reg [1:0] r;
      begin
         axi_wr(a, d, s, r);
         `CHK(r, er)
      end
   endtask
   task rd(input [11:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
      reg [31:0] d;
      reg [1:0]  r;
      begin
         axi_rd(a, d, r);
         `CHK(d & m, e)
         `CHK(r, er)
      end
   endtask
   function [11:0] fa(input [6:0] n);
      fa = {2'b00, 1'b1, n, 2'b00};
   endfunction
   // polls busy, since return ops hold the core two cycles
   task run(input [3:0] op, input d, input [6:0] f, input [7:0] k);
      reg [31:0] st;
      reg [1:0]  r;
      begin
         axi_wr(`OFF_INSTR, {8'h00, k, 1'b0, f, 3'b000, d, op}, 4'hf, r);
         st = 32'h20;
         while (st[`ST_BUSY]) axi_rd(`OFF_STATUS, st, r);
      end
   endtask
   task step(input [3:0] op, input d, input [6:0] f, input [7:0] k,
             input [7:0] ea, input [7:0] ef, input [7:0] es);
      begin
         run(op, d, f, k);
         rd(`OFF_ACC, 32'hff, {24'h0, ea}, `RESP_OKAY);
         rd(fa(f), 32'hff, {24'h0, ef}, `RESP_OKAY);
         rd(`OFF_STATUS, 32'hff, {24'h0, es}, `RESP_OKAY);
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`OFF_STATUS, 32'hff, 32'h18, `RESP_OKAY);
      rd(12'h100, 32'hffffffff, 32'h0, `RESP_SLVERR);
      wr(12'h104, 32'h1, 4'hf, `RESP_SLVERR);
      wr(`OFF_ACC, 32'h50, 4'hf, `RESP_OKAY);
      wr(fa(5), 32'h0a, 4'hf, `RESP_OKAY);
      step(`OP_OR_F, 1'b1, 7'd5, 8'h00, 8'h50, 8'h5a, 8'h18);
      wr(`OFF_ACC, 32'h00, 4'hf, `RESP_OKAY);
      step(`OP_OR_F, 1'b0, 7'd6, 8'h00, 8'h00, 8'h00, 8'h1c);
      wr(`OFF_ACC, 32'ha5, 4'hf, `RESP_OKAY);
      step(`OP_STORE, 1'b0, 7'd127, 8'h00, 8'ha5, 8'ha5, 8'h1c);
      step(`OP_LOAD, 1'b1, 7'd127, 8'h00, 8'ha5, 8'ha5, 8'h18);
      step(`OP_LOAD, 1'b0, 7'd6, 8'h00, 8'h00, 8'h00, 8'h1c);
      wr(`OFF_STATUS, 32'h01, 4'h1, `RESP_OKAY);
      wr(fa(7), 32'h81, 4'hf, `RESP_OKAY);
      step(`OP_RL, 1'b1, 7'd7, 8'h00, 8'h00, 8'h03, 8'h19);
      step(`OP_RL, 1'b0, 7'd7, 8'h00, 8'h07, 8'h03, 8'h18);
      step(`OP_RR, 1'b0, 7'd7, 8'h00, 8'h01, 8'h03, 8'h19);
      step(`OP_RR, 1'b1, 7'd7, 8'h00, 8'h01, 8'h81, 8'h19);
      step(`OP_LITERAL_MINUS_ACCUMULATOR, 1'b0, 7'd7, 8'h00, 8'hff, 8'h81, 8'h18);
      step(`OP_LITERAL_MINUS_ACCUMULATOR, 1'b0, 7'd7, 8'hff, 8'h00, 8'h81, 8'h1f);
      step(`OP_LITERAL_MINUS_ACCUMULATOR, 1'b0, 7'd7, 8'h10, 8'h10, 8'h81, 8'h1b);
      step(`OP_LITERAL_MINUS_ACCUMULATOR, 1'b0, 7'd7, 8'h00, 8'hf0, 8'h81, 8'h1a);
      step(`OP_XOR_LITERAL_ACCUMULATOR, 1'b0, 7'd7, 8'hff, 8'h0f, 8'h81, 8'h1a);
      step(`OP_XOR_LITERAL_ACCUMULATOR, 1'b0, 7'd7, 8'h0f, 8'h00, 8'h81, 8'h1e);
      step(`OP_IDLE, 1'b1, 7'd7, 8'h55, 8'h00, 8'h81, 8'h1e);
      wr(`OFF_STACK, 32'h123, 4'hf, `RESP_OKAY);
      wr(`OFF_STACK, 32'h456, 4'hf, `RESP_OKAY);
      step(`OP_RETURN_LITERAL_IN_ACCUMULATOR, 1'b0, 7'd7, 8'h3c, 8'h3c, 8'h81, 8'h1e);
      rd(`OFF_PC, 32'h1fff, 32'h456, `RESP_OKAY);
      rd(`OFF_STACK, 32'hf, 32'h1, `RESP_OKAY);
      step(`OP_RETURN, 1'b0, 7'd7, 8'h00, 8'h3c, 8'h81, 8'h1e);
      rd(`OFF_PC, 32'h1fff, 32'h123, `RESP_OKAY);
      rd(`OFF_STACK, 32'hf, 32'h0, `RESP_OKAY);
      wr(`OFF_STACK, 32'h0aa, 4'hf, `RESP_OKAY);
      step(`OP_INTERRUPT_EXIT_INSTRUCTION, 1'b0, 7'd7, 8'h00, 8'h3c, 8'h81, 8'h9e);
      rd(`OFF_PC, 32'h1fff, 32'h0aa, `RESP_OKAY);
      run(`OP_SLEEP, 1'b0, 7'd7, 8'h00);
      rd(`OFF_STATUS, 32'hff, 32'hd6, `RESP_OKAY);
      `CHK(oscillator_halted_r, 1'b1)
      // guard keeps running while halted, so allow a few prescaler ticks
      rd(`OFF_GUARD, 32'hf8ff, 32'h0, `RESP_OKAY);
      wr(`OFF_STATUS, 32'h100, 4'h2, `RESP_OKAY);
      `CHK(oscillator_halted_r, 1'b0)
      rd(`OFF_STATUS, 32'hff, 32'h96, `RESP_OKAY);
      give_verdict;
   end
endmodule
